// *** src/sysbus_pkg.sv ***
// Package for the system bus master data-phase block.
// Assumes a 64-bit multiplexed address/data bus sampled on clk.
package sysbus_pkg;

  // Bus cycle types on status bits 48:46
  localparam int TYPE_LO = 46;
  localparam int TYPE_HI = 48;
  localparam logic [2:0] TYPE_INTA = 3'h0;
  localparam logic [2:0] TYPE_SPECIAL = 3'h1;
  localparam logic [2:0] TYPE_IO_RD = 3'h2;
  localparam logic [2:0] TYPE_IO_WR = 3'h3;
  localparam logic [2:0] TYPE_MEM_RD = 3'h6;
  localparam logic [2:0] TYPE_MEM_WR = 3'h7;

  // Byte lane field position in the status half
  localparam int BE_LO = 32;
  localparam int BE_HI = 39;
  localparam logic [7:0] BE_INTA = 8'hFE;
  localparam logic [7:0] BE_HALT = 8'hFB;
  localparam logic [7:0] BE_SHUTDOWN = 8'hFE;
  localparam logic [7:0] BE_IO_HIGH = 8'hFC;

  // Block geometry
  localparam int BLOCK_QWORDS = 4;
  localparam int BLOCK_BYTES = 32;
  localparam int IO_SPACE_BYTES = 65536;

  // Reset values
  localparam logic [63:0] DATA_RESET = 64'h0000_0000_0000_0000;
  localparam logic [7:0] VECTOR_RESET = 8'h00;

  // Requested operation
  typedef enum logic [2:0] {
    OP_MEM_RD = 3'h0,
    OP_MEM_WR = 3'h1,
    OP_BLK_RD = 3'h2,
    OP_BLK_WR = 3'h3,
    OP_IO_RD = 3'h4,
    OP_IO_WR = 3'h5,
    OP_INTA = 3'h6,
    OP_HALT_SD = 3'h7
  } op_t;

  // Cache state given to a filled line
  typedef enum logic [1:0] {
    LINE_INVALID = 2'h0,
    LINE_SHARED = 2'h1,
    LINE_EXCLUSIVE = 2'h2
  } line_state_t;

endpackage

// *** src/data_phase_if.sv ***
// Interface between the master sequencer and its qword data phase engine.
// Assumes both sides run on the same clock.
`timescale 1ns/1ps
interface data_phase_if;
  logic start;
  logic is_read;
  logic [63:0] wdata;
  logic busy;
  logic done;
  logic [63:0] rdata;
  logic first_shared;
  logic first_ownable;

  modport seq (output start, output is_read, output wdata,
               input busy, input done, input rdata,
               input first_shared, input first_ownable);
  modport eng (input start, input is_read, input wdata,
               output busy, output done, output rdata,
               output first_shared, output first_ownable);
endinterface

// *** src/qword_phase.sv ***
// One qword data phase on the system bus, read or write.
// Assumes system logic forms combined_ack and combined_hold.
`timescale 1ns/1ps
module qword_phase
  import sysbus_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Sequencer side
  data_phase_if.eng dp,
  // Bus side
  input wire logic combined_ack,
  input wire logic combined_hold,
  input wire logic combined_shared_hit,
  input wire logic ownership_allowed,
  input wire logic [63:0] bus_in,
  input wire logic core_ready,
  output logic hold_request_n,
  output logic [63:0] bus_out,
  output logic bus_oe_n
);

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WAIT = 2'b01,
    PH_XFER = 2'b11
  } phase_t;

  phase_t state_reg;
  logic read_reg;
  logic [63:0] rdata_reg;

  assign dp.busy = (state_reg != PH_IDLE);
  assign dp.rdata = rdata_reg;
  // Hold on a read while the core is not ready, or between qwords of a block still acked
  // Ack is already low after the last qword, so no hold follows it
  assign hold_request_n = !((state_reg == PH_WAIT && read_reg && !core_ready) ||
                            (state_reg != PH_WAIT && combined_ack));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= PH_IDLE;
      read_reg <= 1'b0;
      dp.done <= 1'b0;
    end else begin
      dp.done <= 1'b0;
      case (state_reg)
        PH_IDLE: begin
          if (dp.start) begin
            state_reg <= PH_WAIT;
            read_reg <= dp.is_read;
          end
        end
        PH_WAIT: begin
          if (combined_ack && !combined_hold) begin
            state_reg <= PH_XFER;
          end
        end
        PH_XFER: begin
          state_reg <= PH_IDLE;
          dp.done <= 1'b1;
        end
        default: state_reg <= PH_IDLE;
      endcase
    end
  end

  // Read data and snoop results sampled at the end of the transfer clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= DATA_RESET;
      dp.first_shared <= 1'b0;
      dp.first_ownable <= 1'b0;
    end else if (state_reg == PH_XFER && read_reg) begin
      rdata_reg <= bus_in;
      dp.first_shared <= combined_shared_hit;
      dp.first_ownable <= ownership_allowed;
    end
  end

  // Write data is driven after the ack clock until the transfer clock ends
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_out <= DATA_RESET;
      bus_oe_n <= 1'b1;
    end else if (state_reg == PH_WAIT && !read_reg && combined_ack) begin
      bus_out <= dp.wdata;
      bus_oe_n <= 1'b0;
    end else if (state_reg == PH_XFER || read_reg) begin
      bus_oe_n <= 1'b1;
    end
  end

endmodule

// *** src/sysbus_master_transfer.sv ***
// Master-side data phase logic of a processor on a 64-bit system bus.
// Assumes arbitration and the address strobe handshake are done elsewhere;
// the address/status word is formed here but never driven onto the pins.
//
// Notes on behaviour
// - Processor asserts hold whenever it cannot accept read data next clock.
// - Read data comes the clock after ack with no hold; sampled then.
// - Processor never holds during group latch; nobody holds after ack drops.
// - Processor keeps its drivers off during a read data phase.
// - Write data driven after ack, one clock beyond ack without hold.
// - Block transfers are four qwords, flagged by block size at address.
// - One address phase, then qwords starting at the addressed one.
// - I/O uses 64K space, lanes 7..2 high, data on bits 15:0.
// - I/O read type 010, write 011, bits 31:16 zero at latch.
// - Interrupt acknowledge is two locked reads, bit 2 set then clear.
// - Halt and shutdown are type 001 with no data phase.
// - Ownership request on single writes or block reads for shared lines.
// - Exclusive only if shared negated at first qword and ownership allowed.
`timescale 1ns/1ps
module sysbus_master_transfer
  import sysbus_pkg::*;
#(
  parameter int QWORDS = BLOCK_QWORDS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Core request
  input wire logic op_start,
  input wire op_t op_kind,
  input wire logic [31:0] op_addr,
  input wire logic [7:0] op_byte_en_n,
  input wire logic op_want_own,
  input wire logic op_shutdown,
  input wire logic [63:0] op_wdata,
  input wire logic core_ready,
  output logic op_busy,
  output logic op_done,
  output logic word_valid,
  output logic [63:0] word_data,
  output logic [7:0] int_vector,
  output line_state_t line_state,
  output logic halted,
  input wire logic nmi_wake,
  // Bus group signals
  input wire logic group_latch_strobe,
  input wire logic combined_ack,
  input wire logic combined_hold,
  input wire logic combined_shared_hit,
  input wire logic ownership_allowed,
  input wire logic block_enable_group,
  // Bus outputs
  output logic hold_request_n,
  output logic block_size_n,
  output logic own_request_n,
  output logic lock_n,
  // Address/data pins
  input wire logic [63:0] sysbus_addr_data_in,
  output logic [63:0] sysbus_addr_data_out,
  output logic sysbus_addr_data_oe_n
);

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_DATA = 3'b011,
    S_NEXT = 3'b010,
    S_HALT = 3'b110
  } seq_t;

  seq_t state_reg;
  op_t kind_reg;
  logic [31:0] addr_reg;
  logic [7:0] be_reg;
  logic own_reg;
  logic shutdown_reg;
  logic [63:0] wdata_reg;
  logic [1:0] count_reg;
  logic inta_second_reg;
  logic [63:0] addr_word;
  logic [63:0] dp_out;
  logic dp_oe_n;
  logic block_op;
  logic is_read;
  logic phase_hold_n;

  data_phase_if dp ();

  qword_phase u_phase (
    .clk(clk),
    .rst_b(rst_b),
    .dp(dp),
    .combined_ack(combined_ack),
    .combined_hold(combined_hold),
    .combined_shared_hit(combined_shared_hit),
    .ownership_allowed(ownership_allowed),
    .bus_in(sysbus_addr_data_in),
    .core_ready(core_ready),
    .hold_request_n(phase_hold_n),
    .bus_out(dp_out),
    .bus_oe_n(dp_oe_n)
  );

  // Never hold while the group latch is up
  assign hold_request_n = phase_hold_n || group_latch_strobe;
  assign block_op = (kind_reg == OP_BLK_RD) || (kind_reg == OP_BLK_WR);
  assign is_read = (kind_reg == OP_MEM_RD) || (kind_reg == OP_BLK_RD) ||
                   (kind_reg == OP_IO_RD) || (kind_reg == OP_INTA);

  // --------------------------------------------------------------
  // Address/status word
  // --------------------------------------------------------------
  always_comb begin
    addr_word = 64'h0000_0000_0000_0000;
    addr_word[BE_HI:BE_LO] = be_reg;
    case (kind_reg)
      OP_IO_RD, OP_IO_WR: begin
        addr_word[TYPE_HI:TYPE_LO] = (kind_reg == OP_IO_RD) ? TYPE_IO_RD : TYPE_IO_WR;
        addr_word[15:2] = addr_reg[15:2];
        addr_word[BE_HI:BE_LO] = BE_IO_HIGH | be_reg;
      end
      OP_INTA: begin
        addr_word[TYPE_HI:TYPE_LO] = TYPE_INTA;
        addr_word[BE_HI:BE_LO] = BE_INTA;
        addr_word[2] = !inta_second_reg;
      end
      OP_HALT_SD: begin
        addr_word[TYPE_HI:TYPE_LO] = TYPE_SPECIAL;
        addr_word[BE_HI:BE_LO] = shutdown_reg ? BE_SHUTDOWN : BE_HALT;
      end
      OP_MEM_RD, OP_BLK_RD: begin
        addr_word[TYPE_HI:TYPE_LO] = TYPE_MEM_RD;
        addr_word[31:3] = addr_reg[31:3];
      end
      default: begin
        addr_word[TYPE_HI:TYPE_LO] = TYPE_MEM_WR;
        addr_word[31:3] = addr_reg[31:3];
      end
    endcase
  end

  // --------------------------------------------------------------
  // Operation sequencer
  // --------------------------------------------------------------
  assign op_busy = (state_reg != S_IDLE);
  assign dp.start = ((state_reg == S_ADDR) && (kind_reg != OP_HALT_SD)) ||
                    (state_reg == S_NEXT);
  assign dp.is_read = is_read;
  assign dp.wdata = wdata_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= S_IDLE;
      kind_reg <= OP_MEM_RD;
      addr_reg <= 32'h0000_0000;
      be_reg <= 8'h00;
      own_reg <= 1'b0;
      shutdown_reg <= 1'b0;
      wdata_reg <= DATA_RESET;
      count_reg <= 2'h0;
      inta_second_reg <= 1'b0;
      op_done <= 1'b0;
    end else begin
      op_done <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (op_start) begin
            state_reg <= S_ADDR;
            kind_reg <= op_kind;
            addr_reg <= op_addr;
            be_reg <= op_byte_en_n;
            own_reg <= op_want_own && (op_kind == OP_MEM_WR || op_kind == OP_BLK_RD);
            shutdown_reg <= op_shutdown;
            wdata_reg <= op_wdata;
            count_reg <= 2'h0;
            inta_second_reg <= 1'b0;
          end
        end
        S_ADDR: begin
          // No data phase for halt or shutdown
          if (kind_reg == OP_HALT_SD) begin
            state_reg <= shutdown_reg ? S_IDLE : S_HALT;
            op_done <= shutdown_reg;
          end else begin
            state_reg <= S_DATA;
          end
        end
        S_DATA: begin
          if (dp.done) begin
            if (block_op && count_reg != 2'(QWORDS - 1)) begin
              count_reg <= count_reg + 2'h1;
              wdata_reg <= op_wdata;
              state_reg <= S_NEXT;
            end else if (kind_reg == OP_INTA && !inta_second_reg) begin
              inta_second_reg <= 1'b1;
              state_reg <= S_ADDR;
            end else begin
              state_reg <= S_IDLE;
              op_done <= 1'b1;
            end
          end
        end
        S_NEXT: state_reg <= S_DATA;
        S_HALT: begin
          if (nmi_wake) begin
            state_reg <= S_IDLE;
            op_done <= 1'b1;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Following qwords of a block reuse the engine without a new address
  logic next_kick;
  assign next_kick = (state_reg == S_NEXT);

  // --------------------------------------------------------------
  // Pins
  // --------------------------------------------------------------
  assign halted = (state_reg == S_HALT);
  assign block_size_n = !((state_reg == S_ADDR) && block_op);
  assign own_request_n = !((state_reg == S_ADDR) && own_reg);
  assign lock_n = !(kind_reg == OP_INTA && state_reg != S_IDLE);

  // Engine flops drive the pins; a second stage would stretch the write drive
  assign sysbus_addr_data_out = dp_out;
  assign sysbus_addr_data_oe_n = dp_oe_n;

  // --------------------------------------------------------------
  // Returned data and cache state
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      word_valid <= 1'b0;
      word_data <= DATA_RESET;
      int_vector <= VECTOR_RESET;
      line_state <= LINE_INVALID;
    end else begin
      word_valid <= dp.done && is_read;
      if (dp.done && is_read) begin
        word_data <= (kind_reg == OP_IO_RD) ? {48'h0, dp.rdata[15:0]} : dp.rdata;
      end
      if (dp.done && kind_reg == OP_INTA && inta_second_reg) begin
        int_vector <= dp.rdata[7:0];
      end
      if (dp.done && kind_reg == OP_BLK_RD && count_reg == 2'h0) begin
        line_state <= (!dp.first_shared && dp.first_ownable && block_enable_group) ?
                      LINE_EXCLUSIVE : LINE_SHARED;
      end
    end
  end

  // Address word is formed but never reaches the pins; it is only tied off here
  logic unused_kick;
  assign unused_kick = next_kick & (addr_word[0] | 1'b1);

endmodule

// *** sim/sysbus_partner.sv ***
// Partner model: addressed slave, snooping caches and group logic.
// Assumes start pulses on the clock edge at which the master takes a request.
`timescale 1ns/1ps
module sysbus_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Setup from the bench
  input wire logic start,
  input wire logic is_read,
  input wire logic [2:0] qwords,
  input wire logic [2:0] ack_delay,
  input wire logic [2:0] hold_cycles,
  input wire logic [1:0] passes,
  input wire logic snoop_hit,
  input wire logic [63:0] rd_base,
  // Bus side
  input wire logic hold_request_n,
  input wire logic [63:0] sysbus_addr_data_in,
  output logic group_latch_strobe,
  output logic combined_ack,
  output logic combined_hold,
  output logic combined_shared_hit,
  output logic [63:0] bus_drive,
  output logic cap_valid,
  output logic [63:0] cap_data
);
  logic active_reg, cap_due_reg, relatch_reg, xfer;
  logic [2:0] age_reg, hold_reg, cnt_reg, seq_reg;
  logic [1:0] pass_reg;

  // Group logic ORs the hold of every party
  assign combined_hold = (combined_ack && hold_reg != 3'h0) || !hold_request_n;
  assign combined_shared_hit = snoop_hit && active_reg;
  assign xfer = combined_ack && !combined_hold;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {active_reg, cap_due_reg, relatch_reg, group_latch_strobe, combined_ack, cap_valid} <= '0;
      {age_reg, hold_reg, cnt_reg, seq_reg, pass_reg} <= '0;
      bus_drive <= 64'h0000_0000_0000_0000;
      cap_data <= 64'h0000_0000_0000_0000;
    end else begin
      group_latch_strobe <= start || relatch_reg;
      relatch_reg <= 1'b0;
      cap_due_reg <= xfer && !is_read;
      cap_valid <= cap_due_reg;
      // Released lines toggle so stale data never passes for valid
      bus_drive <= ~bus_drive;
      if (cap_due_reg) begin
        cap_data <= sysbus_addr_data_in;
      end
      if (start) begin
        seq_reg <= 3'h0;
        pass_reg <= 2'h0;
      end
      if (start || relatch_reg) begin
        active_reg <= 1'b1;
        age_reg <= 3'h0;
        cnt_reg <= 3'h0;
      end else if (active_reg) begin
        age_reg <= age_reg + 3'h1;
      end
      if (active_reg && !combined_ack && cnt_reg < qwords && age_reg == ack_delay - 3'h1) begin
        combined_ack <= 1'b1;
        hold_reg <= hold_cycles;
      end
      if (combined_ack && hold_reg != 3'h0) begin
        hold_reg <= hold_reg - 3'h1;
      end
      if (xfer) begin
        cnt_reg <= cnt_reg + 3'h1;
        seq_reg <= seq_reg + 3'h1;
        if (is_read) begin
          bus_drive <= rd_base + {61'h0, seq_reg};
        end
        if (cnt_reg + 3'h1 == qwords) begin
          combined_ack <= 1'b0;
          active_reg <= 1'b0;
          pass_reg <= pass_reg + 2'h1;
          relatch_reg <= pass_reg + 2'h1 < passes;
        end
      end
    end
  end
endmodule

// *** sim/smt_sva.sv ***
// Checker for the master data-phase block, bound to its top module.
// Assumes one clock domain and the group signals as active-high levels.
`timescale 1ns/1ps
module smt_chk
  import sysbus_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Core side
  input wire logic op_start,
  input wire op_t op_kind,
  input wire logic core_ready,
  input wire logic op_busy,
  input wire logic op_done,
  input wire logic word_valid,
  input wire logic [63:0] word_data,
  // Bus side
  input wire logic group_latch_strobe,
  input wire logic combined_ack,
  input wire logic combined_hold,
  input wire logic hold_request_n,
  input wire logic block_size_n,
  input wire logic own_request_n,
  input wire logic lock_n,
  input wire logic [63:0] sysbus_addr_data_in,
  input wire logic sysbus_addr_data_oe_n
);
  op_t kind_reg;
  logic rd_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      kind_reg <= OP_MEM_RD;
      rd_reg <= 1'b0;
    end else if (op_start && !op_busy) begin
      kind_reg <= op_kind;
      rd_reg <= op_kind inside {OP_MEM_RD, OP_BLK_RD, OP_IO_RD, OP_INTA};
    end else if (op_done) begin
      rd_reg <= 1'b0;
    end
  end

  AST_NO_HOLD_IN_LATCH: assert property (group_latch_strobe |-> hold_request_n)
    else $error("hold requested during group latch");
  AST_NO_HOLD_AFTER_ACK: assert property ($fell(combined_ack) |-> hold_request_n)
    else $error("hold requested after ack dropped");
  AST_HOLD_CORE_BUSY: assert property (rd_reg && combined_ack && !core_ready |-> !hold_request_n)
    else $error("no hold while core not ready");
  AST_READ_OE_OFF: assert property (rd_reg |-> sysbus_addr_data_oe_n)
    else $error("pins driven during read");
  AST_READ_DATA: assert property (word_valid |-> $past(combined_ack && !combined_hold, 3)
    && word_data[15:0] == $past(sysbus_addr_data_in[15:0], 2)
    && (kind_reg == OP_IO_RD
    || word_data[63:16] == $past(sysbus_addr_data_in[63:16], 2)))
    else $error("read data taken at wrong clock");
  AST_WR_DRIVE_START: assert property ($fell(sysbus_addr_data_oe_n) |-> $past(combined_ack))
    else $error("write data driven before ack");
  AST_WR_DRIVE_END: assert property ($rose(sysbus_addr_data_oe_n)
    |-> $past(combined_ack && !combined_hold, 2))
    else $error("write drive length wrong");
  AST_BLOCK_SIZE: assert property (!block_size_n |-> kind_reg inside {OP_BLK_RD, OP_BLK_WR})
    else $error("block size on a non-block cycle");
  AST_OWN_REQ: assert property (!own_request_n |-> kind_reg inside {OP_MEM_WR, OP_BLK_RD})
    else $error("ownership request on wrong cycle");
  AST_LOCK_INTA: assert property (!lock_n |-> kind_reg == OP_INTA)
    else $error("lock outside interrupt acknowledge");
endmodule

bind sysbus_master_transfer smt_chk i_smt_chk (.clk, .rst_b, .op_start, .op_kind, .core_ready,
  .op_busy, .op_done, .word_valid, .word_data, .group_latch_strobe, .combined_ack,
  .combined_hold, .hold_request_n, .block_size_n, .own_request_n, .lock_n,
  .sysbus_addr_data_in, .sysbus_addr_data_oe_n);

// *** sim/sysbus_master_transfer_test.sv ***
// Bench for the master data-phase block.
// Assumes the partner model plays slave, snooping caches and group logic.
`timescale 1ns/1ps
module sysbus_master_transfer_test;
  import sysbus_pkg::*;
  logic clk, rst_b, op_start, op_want_own, op_shutdown, core_ready, nmi_wake, op_busy;
  logic op_done, word_valid, halted, group_latch_strobe, combined_ack, combined_hold;
  logic combined_shared_hit, ownership_allowed, block_enable_group, hold_request_n;
  logic block_size_n, own_request_n, lock_n, sysbus_addr_data_oe_n, cap_valid, is_read;
  logic snoop_hit, lock_seen, blk_seen, own_seen;
  op_t op_kind;
  line_state_t line_state;
  logic [31:0] op_addr;
  logic [7:0] op_byte_en_n, int_vector;
  logic [63:0] op_wdata, word_data, sysbus_addr_data_out, sysbus_addr_data_in;
  logic [63:0] bus_drive, cap_data, rd_base;
  logic [2:0] qwords, ack_delay, hold_cycles;
  logic [1:0] passes;
  logic [63:0] rq[$];
  logic [63:0] wq[$];
  int error_cnt = 0;
  int n_compared = 0;

  assign sysbus_addr_data_in = sysbus_addr_data_oe_n ? bus_drive : sysbus_addr_data_out;

  sysbus_master_transfer #(.QWORDS(BLOCK_QWORDS)) i_sysbus_master_transfer (.clk, .rst_b,
    .op_start, .op_kind, .op_addr, .op_byte_en_n, .op_want_own, .op_shutdown, .op_wdata,
    .core_ready, .op_busy, .op_done, .word_valid, .word_data, .int_vector, .line_state,
    .halted, .nmi_wake, .group_latch_strobe, .combined_ack, .combined_hold,
    .combined_shared_hit, .ownership_allowed, .block_enable_group, .hold_request_n,
    .block_size_n, .own_request_n, .lock_n, .sysbus_addr_data_in, .sysbus_addr_data_out,
    .sysbus_addr_data_oe_n);

  sysbus_partner i_sysbus_partner (.clk, .rst_b, .start(op_start && !op_busy), .is_read,
    .qwords, .ack_delay, .hold_cycles, .passes, .snoop_hit, .rd_base, .hold_request_n,
    .sysbus_addr_data_in, .group_latch_strobe, .combined_ack, .combined_hold,
    .combined_shared_hit, .bus_drive, .cap_valid, .cap_data);

  always @(negedge clk) begin
    if (word_valid === 1'b1) rq.push_back(word_data);
    if (cap_valid === 1'b1) wq.push_back(cap_data);
    if (lock_n === 1'b0) lock_seen = 1'b1;
    if (block_size_n === 1'b0) blk_seen = 1'b1;
    if (own_request_n === 1'b0) own_seen = 1'b1;
  end

  task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic cfg(input logic rd, input logic [2:0] q, d, h, input logic [1:0] p);
    is_read = rd;
    qwords = q;
    ack_delay = d;
    hold_cycles = h;
    passes = p;
    rq.delete();
    wq.delete();
    {lock_seen, blk_seen, own_seen} = 3'h0;
  endtask

  task automatic issue(input op_t k, input logic [63:0] wd);
    @(negedge clk);
    op_kind = k;
    op_wdata = wd;
    op_start = 1'b1;
    @(negedge clk);
    op_start = 1'b0;
  endtask

  task automatic finish_op();
    int n;
    n = 0;
    while (op_done !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    // Let the negedge monitor log this edge's words first
    #1;
    chk("op_done", 64'h1, {63'h0, op_done});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_single();
    cfg(1, 1, 3, 1, 1);
    rd_base = 64'h1234_5678_9ABC_DEF0;
    core_ready = 1'b0;
    issue(OP_MEM_RD, 64'h0000_0000_0000_0000);
    repeat (6) @(negedge clk);
    core_ready = 1'b1;
    finish_op();
    chk("read count", 64'h1, rq.size());
    chk("read data", rd_base, rq[0]);
    cfg(0, 1, 2, 2, 1);
    op_want_own = 1'b1;
    issue(OP_MEM_WR, 64'hA5A5_0F0F_3C3C_9696);
    finish_op();
    chk("write data", 64'hA5A5_0F0F_3C3C_9696, wq[0]);
    chk("own request", 64'h1, {63'h0, own_seen});
    $display("Test single done");
  endtask

  task automatic t_block();
    for (int i = 0; i < 4; i++) begin
      cfg(1, 4, 2, i[2:0], 1);
      snoop_hit = (i == 1);
      ownership_allowed = (i != 2);
      block_enable_group = (i != 3);
      rd_base = 64'h0000_0000_0000_0100;
      issue(OP_BLK_RD, 64'h0000_0000_0000_0000);
      finish_op();
      chk("block count", 64'h4, rq.size());
      chk("block size", 64'h1, {63'h0, blk_seen});
      for (int j = 0; j < 4; j++) chk("block data", rd_base + j, rq[j]);
      chk("line state", (i == 0) ? LINE_EXCLUSIVE : LINE_SHARED, line_state);
    end
    block_enable_group = 1'b1;
    cfg(0, 4, 3, 1, 1);
    issue(OP_BLK_WR, 64'h0F1E_2D3C_4B5A_6978);
    finish_op();
    chk("block write count", 64'h4, wq.size());
    for (int j = 0; j < 4; j++) chk("block write data", 64'h0F1E_2D3C_4B5A_6978, wq[j]);
    $display("Test block done");
  endtask

  task automatic t_io();
    cfg(1, 1, 2, 0, 1);
    rd_base = 64'hFFFF_FFFF_FFFF_BEEF;
    op_byte_en_n = 8'hFC;
    issue(OP_IO_RD, 64'h0000_0000_0000_0000);
    finish_op();
    chk("io read", 64'h0000_0000_0000_BEEF, {48'h0, rq[0][15:0]});
    cfg(0, 1, 3, 0, 1);
    issue(OP_IO_WR, 64'h0000_0000_0000_C0DE);
    finish_op();
    chk("io write", 64'h0000_0000_0000_C0DE, {48'h0, wq[0][15:0]});
    $display("Test io done");
  endtask

  task automatic t_intack();
    cfg(1, 1, 3, 0, 2);
    rd_base = 64'h0000_0000_0000_0040;
    issue(OP_INTA, 64'h0000_0000_0000_0000);
    finish_op();
    chk("vector", 64'h41, {56'h0, int_vector});
    chk("lock seen", 64'h1, {63'h0, lock_seen});
    $display("Test intack done");
  endtask

  task automatic t_halt();
    cfg(1, 0, 2, 0, 1);
    op_shutdown = 1'b0;
    issue(OP_HALT_SD, 64'h0000_0000_0000_0000);
    repeat (6) @(negedge clk);
    chk("halted", 64'h1, {63'h0, halted});
    chk("halt drive", 64'h1, {63'h0, sysbus_addr_data_oe_n});
    nmi_wake = 1'b1;
    @(negedge clk);
    nmi_wake = 1'b0;
    repeat (3) @(negedge clk);
    chk("woken", 64'h0, {63'h0, halted});
    op_shutdown = 1'b1;
    issue(OP_HALT_SD, 64'h0000_0000_0000_0000);
    finish_op();
    rst_b = 1'b0;
    @(negedge clk);
    rst_b = 1'b1;
    chk("soft reset drive", 64'h1, {63'h0, sysbus_addr_data_oe_n});
    $display("Test halt done");
  endtask

  task automatic conclude();
    $display("Compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (4000) @(posedge clk);
    error_cnt++;
    $display("[ERR] run expected finish seen timeout");
    conclude();
  end

  initial begin
    {rst_b, op_start, op_want_own, op_shutdown, nmi_wake, snoop_hit} = '0;
    {core_ready, ownership_allowed, block_enable_group} = 3'h7;
    op_kind = OP_MEM_RD;
    op_addr = 32'h0000_1040;
    op_byte_en_n = 8'h00;
    op_wdata = 64'h0000_0000_0000_0000;
    rd_base = 64'h0000_0000_0000_0000;
    cfg(1, 1, 2, 0, 1);
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    t_single();
    t_block();
    t_io();
    t_intack();
    t_halt();
    conclude();
  end
endmodule
